/* File: hdl/eas_pkg.sv */
// shared constants and types of the serial eeprom access sequencer
package eas_pkg;

	// ****************************************************************
	// array and page geometry
	// ****************************************************************
	localparam int ADDR_W = 16;
	localparam int BYTE_W = 8;
	localparam int PAGE_W = 7;
	localparam int PAGE_BYTES = 128;
	localparam int IDX_W = 8;
	localparam logic [ADDR_W-1:0] PTR_RESET = 16'h0000;

	// ****************************************************************
	// control byte layout and bit timing
	// ****************************************************************
	localparam logic [3:0] CTRL_CODE = 4'ha;
	localparam int CTRL_CODE_MSB = 7;
	localparam int CTRL_CODE_LSB = 4;
	localparam int CTRL_CS_MSB = 3;
	localparam int CTRL_CS_LSB = 1;
	localparam int CTRL_RW_BIT = 0;
	localparam logic [3:0] BIT_FIRST = 4'h1;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [7:0] TX_UNDERRUN = 8'hff;

	// ****************************************************************
	// programming cycle length in system clocks (value arbitrary)
	// ****************************************************************
	localparam int unsigned PROG_CYCLES_DEF = 5000;

	// ****************************************************************
	// link-side frame states
	// ****************************************************************
	typedef enum logic [2:0] {
		LS_IDLE,
		LS_CTRL,
		LS_ADDR_HI,
		LS_ADDR_LO,
		LS_WDATA,
		LS_RDATA
	} eas_link_state_t;

endpackage

/* File: hdl/eas_sequencer.sv */
// serial eeprom access sequencer: link-side byte engine and system-side array with page programming
//
// Functional notes
// - byte write: control, address high, address low, one data byte, each acknowledged, then stop
// - stop after write data starts timed programming; no acknowledge while it runs
// - write protect high: writes acknowledged, nothing programmed, ready at once
// - after a byte write the pointer holds the next location
// - partial page write keeps contents of bytes not supplied
// - extra data bytes go to the page buffer, programmed only after stop
// - each written byte increments only the low seven pointer bits
// - more than a page of bytes wraps and overwrites earlier buffer entries
// - page writes wrap to the start of the same page, never the next
// - write protect high blocks writes over the whole address range
// - write protect sampled once at stop of each write command
// - after programming, a write control byte is acknowledged again
// - read bit one selects read: current, random and sequential reads
// - current-address read returns byte one past the last accessed
// - read: acknowledge control, send one byte, stop on master not-acknowledge
// - random read: pointer loaded from address bytes before repeated start
// - after a read the pointer holds the location after the returned byte
// - each master acknowledge sends the next byte from the incremented pointer
// - read pointer spans full range and wraps from top to bottom
// - respond only to matching type code and chip-select levels
// - data line released after a byte the master did not acknowledge
// - two address bytes carry all sixteen bits, high byte first
`timescale 1ns/100ps
`default_nettype none

module eas_sequencer #(
	parameter int unsigned PROG_CYCLES = eas_pkg::PROG_CYCLES_DEF
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic scl_i,
	input wire logic bus_start_i,
	input wire logic bus_stop_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic chip_select_bit_zero_i,
	input wire logic chip_select_bit_one_i,
	input wire logic chip_select_bit_two_i,
	input wire logic write_protect_i,
	output logic busy_o
);
	import eas_pkg::*;

	// ****************************************************************
	// helpers
	// ****************************************************************

	// advance inside the page only, upper bits untouched
	function automatic logic [ADDR_W-1:0] next_in_page(input logic [ADDR_W-1:0] p);
		next_in_page = {p[ADDR_W-1:PAGE_W], p[PAGE_W-1:0] + 7'h01};
	endfunction

	// three-stage pin filter: a change counts when stages two and three agree
	function automatic logic [2:0] pin_agree(input logic [2:0] held, input logic [2:0] s2,
		input logic [2:0] s3);
		pin_agree = (s2 == s3) ? s3 : held;
	endfunction

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [BYTE_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [BYTE_W-1:0] page_buf [0:PAGE_BYTES-1];

	// link domain
	logic rst_l1_r;
	logic rst_l_r;
	logic [2:0] cs_s1_r;
	logic [2:0] cs_s2_r;
	logic [2:0] cs_s3_r;
	logic [2:0] cs_r;
	logic busy_l1_r;
	logic busy_l_r;
	logic done_l1_r;
	logic done_l2_r;
	logic done_seen_r;
	logic pf_l1_r;
	logic pf_l2_r;
	eas_link_state_t state_r;
	eas_link_state_t after_r;
	eas_link_state_t byte_next;
	logic [3:0] bit_r;
	logic [BYTE_W-1:0] shift_r;
	logic [BYTE_W-1:0] rx_byte;
	logic [BYTE_W-1:0] tx_r;
	logic [BYTE_W-1:0] addr_hi_r;
	logic [ADDR_W-1:0] ptr_r;
	logic [ADDR_W-PAGE_W-1:0] page_r;
	logic [PAGE_BYTES-1:0] valid_r;
	logic ack_r;
	logic byte_ack;
	logic req_tgl_r;
	logic pend_r;
	logic sda_oe_r;
	logic rx_state;
	logic frame_run;
	logic rx_done;
	logic ctrl_ok;
	logic load_tx;

	// system domain
	logic [1:0] pin_s1_r;
	logic [1:0] pin_s2_r;
	logic [1:0] pin_s3_r;
	logic [1:0] pin_r;
	logic stop_prev_r;
	logic stop_evt;
	logic pend_s1_r;
	logic pend_s_r;
	logic req_s1_r;
	logic req_s2_r;
	logic req_seen_r;
	logic pf_tgl_r;
	logic [ADDR_W-1:0] ptr_hold_r;
	logic [BYTE_W-1:0] rd_data_r;
	logic busy_r;
	logic done_tgl_r;
	logic [IDX_W-1:0] prog_idx_r;
	logic [31:0] timer_r;
	logic sda_o_r;

	// ****************************************************************
	// link domain: reset and input conditioning
	// ****************************************************************

	// reset reaches the link logic only while the serial clock runs
	always_ff @(posedge scl_i) begin
		rst_l1_r <= reset_i;
		rst_l_r <= rst_l1_r;
	end

	// chip-select straps come from pins, filtered before compare
	always_ff @(posedge scl_i) begin
		cs_s1_r <= {chip_select_bit_two_i, chip_select_bit_one_i, chip_select_bit_zero_i};
		cs_s2_r <= cs_s1_r;
		cs_s3_r <= cs_s2_r;
		if (rst_l_r) begin
			cs_r <= 3'h0;
		end else begin
			cs_r <= pin_agree(cs_r, cs_s2_r, cs_s3_r);
		end
	end

	// busy level, completion toggle and prefetch answer from the system side
	always_ff @(posedge scl_i) begin
		busy_l1_r <= busy_r;
		busy_l_r <= busy_l1_r;
		done_l1_r <= done_tgl_r;
		done_l2_r <= done_l1_r;
		pf_l1_r <= pf_tgl_r;
		pf_l2_r <= pf_l1_r;
	end

	// ****************************************************************
	// link domain: byte decode
	// ****************************************************************
	assign rx_byte = {shift_r[BYTE_W-2:0], sda_i};
	assign rx_state = (state_r == LS_CTRL) || (state_r == LS_ADDR_HI) || (state_r == LS_ADDR_LO) ||
		(state_r == LS_WDATA);
	assign frame_run = !rst_l_r && !bus_start_i;
	assign rx_done = frame_run && rx_state && (bit_r == BIT_LAST);
	assign ctrl_ok = (rx_byte[CTRL_CODE_MSB:CTRL_CODE_LSB] == CTRL_CODE) &&
		(rx_byte[CTRL_CS_MSB:CTRL_CS_LSB] == cs_r) && !busy_l_r;
	// byte to transmit is taken on control acknowledge or master acknowledge
	assign load_tx = frame_run && (bit_r == BIT_ACK) &&
		(((state_r == LS_CTRL) && ack_r && (after_r == LS_RDATA)) ||
		((state_r == LS_RDATA) && !sda_i));

	// acknowledge and follow-on state for the byte just completed
	always_comb begin
		byte_ack = 1'b0;
		byte_next = LS_IDLE;
		case (state_r)
			LS_CTRL: begin
				byte_ack = ctrl_ok;
				if (!ctrl_ok) begin
					byte_next = LS_IDLE;
				end else if (rx_byte[CTRL_RW_BIT]) begin
					byte_next = LS_RDATA;
				end else begin
					byte_next = LS_ADDR_HI;
				end
			end
			LS_ADDR_HI: begin
				byte_ack = 1'b1;
				byte_next = LS_ADDR_LO;
			end
			LS_ADDR_LO: begin
				byte_ack = 1'b1;
				byte_next = LS_WDATA;
			end
			LS_WDATA: begin
				byte_ack = 1'b1;
				byte_next = LS_WDATA;
			end
			default: begin
				byte_ack = 1'b0;
				byte_next = LS_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// link domain: frame sequencing
	// ****************************************************************

	// bit counter and state; a start always restarts the control byte
	always_ff @(posedge scl_i) begin
		if (rst_l_r) begin
			state_r <= LS_IDLE;
			after_r <= LS_IDLE;
			bit_r <= 4'h0;
			shift_r <= 8'h00;
			ack_r <= 1'b0;
		end else if (bus_start_i) begin
			state_r <= LS_CTRL;
			bit_r <= BIT_FIRST;
			shift_r <= {7'h00, sda_i};
			ack_r <= 1'b0;
		end else begin
			case (state_r)
				LS_IDLE: begin
					bit_r <= 4'h0;
				end
				LS_RDATA: begin
					if (bit_r == BIT_ACK) begin
						bit_r <= 4'h0;
						if (sda_i) begin
							state_r <= LS_IDLE;
						end
					end else begin
						bit_r <= bit_r + 4'h1;
					end
				end
				default: begin
					if (bit_r == BIT_ACK) begin
						bit_r <= 4'h0;
						ack_r <= 1'b0;
						state_r <= after_r;
					end else begin
						shift_r <= rx_byte;
						bit_r <= bit_r + 4'h1;
						if (bit_r == BIT_LAST) begin
							ack_r <= byte_ack;
							after_r <= byte_next;
						end
					end
				end
			endcase
		end
	end

	// address pointer; each change asks the system side for a fresh byte
	always_ff @(posedge scl_i) begin
		if (rst_l_r) begin
			ptr_r <= PTR_RESET;
			addr_hi_r <= 8'h00;
			req_tgl_r <= 1'b0;
		end else if (rx_done && (state_r == LS_ADDR_HI)) begin
			addr_hi_r <= rx_byte;
		end else if (rx_done && (state_r == LS_ADDR_LO)) begin
			ptr_r <= {addr_hi_r, rx_byte};
			req_tgl_r <= ~req_tgl_r;
		end else if (rx_done && (state_r == LS_WDATA)) begin
			ptr_r <= next_in_page(ptr_r);
			req_tgl_r <= ~req_tgl_r;
		end else if (load_tx) begin
			ptr_r <= ptr_r + 16'h0001;
			req_tgl_r <= ~req_tgl_r;
		end
	end

	// transmit shifter; an unanswered prefetch sends all ones
	always_ff @(posedge scl_i) begin
		if (rst_l_r) begin
			tx_r <= 8'h00;
		end else if (load_tx) begin
			tx_r <= (pf_l2_r == req_tgl_r) ? rd_data_r : TX_UNDERRUN;
		end else if (frame_run && (state_r == LS_RDATA) && (bit_r != BIT_ACK)) begin
			tx_r <= {tx_r[BYTE_W-2:0], 1'b1};
		end
	end

	// page buffer fill; cleared only when the system side has consumed it
	always_ff @(posedge scl_i) begin
		if (rst_l_r) begin
			valid_r <= '0;
			pend_r <= 1'b0;
			page_r <= '0;
			done_seen_r <= 1'b0;
		end else begin
			if (done_l2_r != done_seen_r) begin
				done_seen_r <= done_l2_r;
				valid_r <= '0;
				pend_r <= 1'b0;
			end
			// a new byte wins over the clear in the same edge
			if (rx_done && (state_r == LS_WDATA)) begin
				valid_r[ptr_r[PAGE_W-1:0]] <= 1'b1;
				pend_r <= 1'b1;
				page_r <= ptr_r[ADDR_W-1:PAGE_W];
			end
		end
	end

	// buffer storage; no reset, the valid bits say what is meaningful
	always_ff @(posedge scl_i) begin
		if (rx_done && (state_r == LS_WDATA)) begin
			page_buf[ptr_r[PAGE_W-1:0]] <= rx_byte;
		end
	end

	// data line changes only while the clock is low
	always_ff @(negedge scl_i) begin
		if (rst_l_r) begin
			sda_oe_r <= 1'b0;
		end else if ((state_r == LS_RDATA) && (bit_r != BIT_ACK)) begin
			sda_oe_r <= ~tx_r[BYTE_W-1];
		end else begin
			sda_oe_r <= ack_r && (bit_r == BIT_ACK);
		end
	end

	// ****************************************************************
	// system domain: pins and crossings
	// ****************************************************************

	// stop and write-protect arrive from pins
	always_ff @(posedge clk_sys_i) begin
		pin_s1_r <= {bus_stop_i, write_protect_i};
		pin_s2_r <= pin_s1_r;
		pin_s3_r <= pin_s2_r;
		if (reset_i) begin
			pin_r <= 2'b00;
			stop_prev_r <= 1'b0;
		end else begin
			if (pin_s2_r == pin_s3_r) begin
				pin_r <= pin_s3_r;
			end
			stop_prev_r <= pin_r[1];
		end
	end
	assign stop_evt = pin_r[1] && !stop_prev_r;

	// write-pending level and prefetch request from the link side
	always_ff @(posedge clk_sys_i) begin
		pend_s1_r <= pend_r;
		pend_s_r <= pend_s1_r;
		req_s1_r <= req_tgl_r;
		req_s2_r <= req_s1_r;
	end

	// prefetch: the pointer is stable while its request toggle travels
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			req_seen_r <= 1'b0;
			pf_tgl_r <= 1'b0;
			ptr_hold_r <= PTR_RESET;
		end else begin
			if (req_s2_r != req_seen_r) begin
				req_seen_r <= req_s2_r;
				ptr_hold_r <= ptr_r;
			end
			pf_tgl_r <= req_seen_r;
		end
	end

	// read port re-reads every cycle, so data is fresh after programming
	always_ff @(posedge clk_sys_i) begin
		rd_data_r <= mem[ptr_hold_r];
	end

	// ****************************************************************
	// system domain: programming cycle
	// ****************************************************************

	// protect is looked at only on the stop edge of a write
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			busy_r <= 1'b0;
			done_tgl_r <= 1'b0;
			prog_idx_r <= 8'h00;
			timer_r <= 32'h0000_0000;
		end else if (!busy_r) begin
			if (stop_evt && pend_s_r) begin
				if (pin_r[0]) begin
					done_tgl_r <= ~done_tgl_r;
				end else begin
					busy_r <= 1'b1;
					prog_idx_r <= 8'h00;
					timer_r <= 32'h0000_0000;
				end
			end
		end else begin
			timer_r <= timer_r + 32'h0000_0001;
			if (!prog_idx_r[IDX_W-1]) begin
				prog_idx_r <= prog_idx_r + 8'h01;
			end
			if (timer_r == 32'(PROG_CYCLES - 1)) begin
				busy_r <= 1'b0;
				done_tgl_r <= ~done_tgl_r;
			end
		end
	end

	// whole page walked; bytes not supplied keep their old value
	always_ff @(posedge clk_sys_i) begin
		if (busy_r && !prog_idx_r[IDX_W-1] && valid_r[prog_idx_r[PAGE_W-1:0]]) begin
			mem[{page_r, prog_idx_r[PAGE_W-1:0]}] <= page_buf[prog_idx_r[PAGE_W-1:0]];
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************

	// open-drain: the driven level is always low
	always_ff @(posedge clk_sys_i) begin
		sda_o_r <= 1'b0;
	end

	assign sda_o = sda_o_r;
	assign sda_oe_o = sda_oe_r;
	assign busy_o = busy_r;

endmodule

`default_nettype wire

/* File: tb/eas_props.sv */
// assertion checker for the serial eeprom access sequencer
`timescale 1ns/100ps
`default_nettype none
module eas_props #(
	parameter int unsigned PROG_CYCLES = 200
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic scl_i,
	input wire logic bus_start_i,
	input wire logic bus_stop_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic chip_select_bit_zero_i,
	input wire logic chip_select_bit_one_i,
	input wire logic chip_select_bit_two_i,
	input wire logic write_protect_i,
	input wire logic busy_o
);
	import eas_pkg::*;
	// ********
	// frame tracking helpers
	// ********
	logic [3:0] pos_r;
	logic first_r;
	logic bsy_any_r;
	logic bsy_all_r;
	logic [7:0] sh_r;
	logic [31:0] bcnt_r;
	logic match;
	// bit position in the byte, restarted by each start
	always_ff @(posedge scl_i) begin
		pos_r <= (reset_i || bus_start_i) ? 4'h1 : ((pos_r == 4'h8) ? 4'h0 : pos_r + 4'h1);
	end
	// first byte of a frame is the control byte
	always_ff @(posedge scl_i) begin
		first_r <= (reset_i || bus_start_i) ? 1'b1 : (first_r && pos_r != 4'h8);
	end
	// busy seen over the control byte; partial overlap is left unjudged
	always_ff @(posedge scl_i) begin
		bsy_any_r <= bus_start_i ? busy_o : (bsy_any_r | busy_o);
		bsy_all_r <= bus_start_i ? busy_o : (bsy_all_r & busy_o);
	end
	always_ff @(posedge scl_i) begin
		sh_r <= {sh_r[6:0], sda_i};
	end
	// length of the current busy stretch
	always_ff @(posedge clk_sys_i) begin
		bcnt_r <= (reset_i || !busy_o) ? 32'h0 : bcnt_r + 32'h1;
	end
	assign match = (sh_r[7:4] == CTRL_CODE) &&
		(sh_r[3:1] == {chip_select_bit_two_i, chip_select_bit_one_i, chip_select_bit_zero_i});
	// ********
	// properties
	// ********
	sequence s_quiet;
		!sda_oe_o [*8];
	endsequence
	property p_ctrl_quiet;
		@(posedge scl_i) disable iff (reset_i) bus_start_i |-> s_quiet;
	endproperty
	a_ctrl_quiet: assert property (p_ctrl_quiet) else $error("line driven in control byte");
	property p_ack_match;
		@(posedge scl_i) disable iff (reset_i) first_r && pos_r == 4'h8 && !bsy_any_r |-> sda_oe_o == match;
	endproperty
	a_ack_match: assert property (p_ack_match) else $error("control byte ack wrong");
	property p_busy_nack;
		@(posedge scl_i) disable iff (reset_i) first_r && pos_r == 4'h8 && bsy_all_r |-> !sda_oe_o;
	endproperty
	a_busy_nack: assert property (p_busy_nack) else $error("ack while busy");
	property p_nack_release;
		@(posedge scl_i) disable iff (reset_i) pos_r == 4'h8 && sda_i |=> s_quiet;
	endproperty
	a_nack_release: assert property (p_nack_release) else $error("line not released");
	property p_stop_release;
		@(posedge clk_sys_i) disable iff (reset_i) bus_stop_i |-> !sda_oe_o;
	endproperty
	a_stop_release: assert property (p_stop_release) else $error("driving after stop");
	property p_drive_low;
		@(posedge clk_sys_i) disable iff (reset_i) sda_oe_o |-> !sda_o;
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("line driven high");
	property p_busy_len;
		@(posedge clk_sys_i) disable iff (reset_i)
			$fell(busy_o) |-> bcnt_r >= PROG_CYCLES - 1 && bcnt_r <= PROG_CYCLES + 1;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("programming length wrong");
	property p_busy_wp;
		@(posedge clk_sys_i) disable iff (reset_i) $rose(busy_o) |-> !$past(write_protect_i, 4);
	endproperty
	a_busy_wp: assert property (p_busy_wp) else $error("programming while protected");
	property p_busy_stop;
		@(posedge clk_sys_i) disable iff (reset_i) $rose(busy_o) |-> $past(bus_stop_i, 2);
	endproperty
	a_busy_stop: assert property (p_busy_stop) else $error("programming without stop");
endmodule
bind eas_sequencer eas_props #(.PROG_CYCLES(PROG_CYCLES)) i_props (.clk_sys_i, .reset_i, .scl_i,
	.bus_start_i, .bus_stop_i, .sda_i, .sda_o, .sda_oe_o, .chip_select_bit_zero_i,
	.chip_select_bit_one_i, .chip_select_bit_two_i, .write_protect_i, .busy_o);
`default_nettype wire

/* File: tb/eas_master.sv */
// two-wire bus master model: serial clock, start and stop strobes
`timescale 1ns/100ps
`default_nettype none
module eas_master (
	output logic scl_o,
	output logic start_o,
	output logic stop_o,
	output logic oe_o,
	input wire logic sda_i,
	output logic res_v,
	output logic [7:0] res_d
);
	int stretch = 0;
	// idle bus: clock parked high, line released
	initial begin
		scl_o = 1'b1;
		start_o = 1'b0;
		stop_o = 1'b1;
		oe_o = 1'b0;
		res_v = 1'b0;
		res_d = 8'h00;
	end
	task automatic post(input logic [7:0] v);
		res_d = v;
		res_v = 1'b1;
		#1 res_v = 1'b0;
	endtask
	// free clocks while reset is applied and for some periods after its release, before the first frame
	task automatic tog(input int n);
		repeat (n) begin
			#6 scl_o = 1'b0;
			#6 scl_o = 1'b1;
		end
	endtask
	// data changes in the low phase, sampled late in the high phase
	task automatic bitx(input logic b, output logic r);
		oe_o = !b;
		#(3 + stretch) scl_o = 1'b1;
		#6 r = sda_i;
		scl_o = 1'b0;
		start_o = 1'b0;
		#3;
	endtask
	task automatic start();
		oe_o = 1'b0;
		#3 scl_o = 1'b1;
		#3 oe_o = 1'b1;
		start_o = 1'b1;
		stop_o = 1'b0;
		#3 scl_o = 1'b0;
		#3;
	endtask
	task automatic stop();
		oe_o = 1'b1;
		#3 scl_o = 1'b1;
		#3 oe_o = 1'b0;
		stop_o = 1'b1;
		#150;
	endtask
	task automatic wbyte(input logic [7:0] d, input logic rec, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
		end
		bitx(1'b1, r);
		a = !r;
		if (rec) post({7'h00, a});
	endtask
	task automatic rbyte(input logic ack);
		logic [7:0] d;
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, d[i]);
		end
		bitx(!ack, r);
		oe_o = 1'b0;
		post(d);
	endtask
endmodule
`default_nettype wire

/* File: tb/eas_sequencer_tb.sv */
// self-checking testbench of the serial eeprom access sequencer
`timescale 1ns/100ps
`default_nettype none
module eas_sequencer_tb;
	import eas_pkg::*;
	localparam int unsigned PROG = 200;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic wp = 1'b0;
	logic [2:0] cs = 3'h0;
	logic scl, bstart, bstop, m_oe, d_oe, d_out, busy, res_v;
	logic [7:0] res_d;
	wire logic sda;
	logic [8:0] q[$];
	logic [7:0] mem [logic [15:0]];
	logic [15:0] ptr;
	int bad_count = 0;
	int num_checks = 0;
	// open-drain line with pull-up
	assign sda = !(m_oe | d_oe);
	initial begin
		forever #5 clk_sys_i = !clk_sys_i;
	end
	eas_sequencer #(.PROG_CYCLES(PROG)) i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .scl_i(scl),
		.bus_start_i(bstart), .bus_stop_i(bstop), .sda_i(sda), .sda_o(d_out), .sda_oe_o(d_oe),
		.chip_select_bit_zero_i(cs[0]), .chip_select_bit_one_i(cs[1]), .chip_select_bit_two_i(cs[2]),
		.write_protect_i(wp), .busy_o(busy));
	eas_master i_mst (.scl_o(scl), .start_o(bstart), .stop_o(bstop), .oe_o(m_oe), .sda_i(sda),
		.res_v(res_v), .res_d(res_d));
	// ********
	// checking
	// ********
	task automatic fail(input string m);
		$display("CHECK FAILED %0t %s", $time, m);
		bad_count++;
	endtask
	task automatic chk_ack(input logic g, input logic e);
		num_checks++;
		if (g !== e) fail("acknowledge");
	endtask
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) fail("read data");
	endtask
	// oldest note against each result the master reports
	always @(posedge res_v) begin
		if (q.size() == 0) begin
			fail("unexpected result");
		end else if (q[0][8]) begin
			chk_byte(res_d, q[0][7:0]);
			void'(q.pop_front());
		end else begin
			chk_ack(res_d[0], q[0][0]);
			void'(q.pop_front());
		end
	end
	task automatic end_of_test();
		if (bad_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ********
	// bus operations
	// ********
	function automatic logic [7:0] ctl(input logic rd);
		return {CTRL_CODE, cs, rd};
	endfunction
	task automatic sb(input logic [7:0] d, input logic e);
		logic a;
		q.push_back({1'b0, 7'h00, e});
		i_mst.wbyte(d, 1'b1, a);
	endtask
	task automatic seta(input logic [15:0] a);
		i_mst.start();
		sb(ctl(1'b0), 1'b1);
		sb(a[15:8], 1'b1);
		sb(a[7:0], 1'b1);
		ptr = a;
	endtask
	// protect level flips after stop: the decision at stop must hold
	task automatic wr(input logic [15:0] a, input int n, input logic p);
		logic [7:0] d;
		logic k;
		@(negedge clk_sys_i);
		wp = p;
		seta(a);
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			sb(d, 1'b1);
			if (!p) mem[{a[15:7], 7'(a[6:0] + 7'(i))}] = d;
		end
		ptr = {a[15:7], 7'(a[6:0] + 7'(n))};
		i_mst.stop();
		@(negedge clk_sys_i);
		wp = !p;
		i_mst.start();
		sb(ctl(1'b0), p);
		k = p;
		for (int i = 0; i < 100 && !k; i++) begin
			i_mst.start();
			i_mst.wbyte(ctl(1'b0), 1'b0, k);
		end
		if (!k) begin
			fail("poll timeout");
			end_of_test();
		end else begin
			i_mst.stop();
		end
	endtask
	task automatic rd(input logic rnd, input logic [15:0] a, input int n);
		if (rnd) seta(a);
		i_mst.start();
		sb(ctl(1'b1), 1'b1);
		for (int i = 1; i <= n; i++) begin
			q.push_back({1'b1, mem[ptr]});
			ptr++;
			i_mst.rbyte(i < n);
		end
		i_mst.stop();
	endtask
	// ********
	// main sequence
	// ********
	initial begin
		@(negedge clk_sys_i);
		void'($urandom(32'h3a5d62ff));
		cs = 3'($urandom);
		fork
			i_mst.tog(10);
			begin
				repeat (5) @(negedge clk_sys_i);
				reset_i = 1'b0;
			end
		join
		wr(16'h0000, 1, 1'b0);
		wr(16'hff85, 130, 1'b0);
		i_mst.stretch = 20;
		rd(1'b0, 16'h0000, 3);
		i_mst.stretch = 0;
		wr(16'hffa0, 1, 1'b0);
		rd(1'b0, 16'h0000, 1);
		// protect rose during that programming cycle: the byte must still have landed
		rd(1'b1, 16'hffa0, 1);
		wr(16'hffc8, 2, 1'b0);
		rd(1'b1, 16'hffc6, 6);
		rd(1'b0, 16'h0000, 1);
		wr(16'hffe0, 3, 1'b1);
		rd(1'b1, 16'hffe0, 1);
		rd(1'b1, 16'hfffe, 3);
		// foreign type code, then foreign chip select: both ignored
		for (int i = 0; i < 2; i++) begin
			i_mst.start();
			sb(i ? {CTRL_CODE, ~cs, 1'b1} : {4'hb, cs, 1'b0}, 1'b0);
			sb(8'h00, 1'b0);
			i_mst.stop();
		end
		if (q.size() != 0) fail("missing result");
		end_of_test();
	end
	initial begin
		#800000;
		fail("timeout");
		end_of_test();
	end
endmodule
`default_nettype wire
